// file: src/pis_sources.sv
// Interrupt source flags, enables and CPU request generation
// Notes on behaviour
// (RL1) External pin low latches pending request
// (RL2) Lock toggle sets flag; enable gates request
// (RL3) Timer wrap to zero sets wrap flag
// (RL4) Channel capture or compare sets channel flag
// (RL5) SPI receive transfer sets receive full flag
// (RL6) SPI transmit transfer sets transmit empty flag
// (RL7) Slave select rising mid-transfer flags fault
// (RL8) Master with select low flags fault
// (RL9) SPI byte before read sets lost flag
// (RL10) UART handoff to shifter sets empty flag
// (RL11) UART done when both empty, no break
// (RL12) UART receive transfer sets full flag
// (RL13) Ten or eleven high bits set idle
// (RL14) UART new character before read: overrun
// (RL15) UART noise in any bit sets flag
// (RL16) Low stop bit sets framing flag
// (RL17) Parity mismatch sets parity flag
// (RL18) Any keypad pin low latches request
// (RL19) Converter requests after each conversion when enabled
// (RL20) Tick rollover at selected rate sets flag
// (RL21) Software writes one to acknowledge tick
// (RL22) Global mask blocks cpu_irq; irq_request is not masked
// (RL23) Shared lines OR each flag with enable
`timescale 1ns/10ps
module pis_sources
  import pis_pkg::*;
#(
  parameter int unsigned TMR_W = PIS_TMR_W,
  parameter int unsigned KEY_W = PIS_KEY_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic global_mask,
  input wire logic ext_request_pin,
  input wire logic ext_clear,
  input wire logic lock_status,
  input wire logic lock_change_irq_enable,
  input wire logic lock_change_clear,
  input wire logic [1:0] timer_count_tick,
  input wire logic [2*TMR_W-1:0] timer_count,
  input wire logic [2*TMR_W-1:0] timer_modulo,
  input wire logic [1:0] timer_wrap_irq_enable,
  input wire logic [1:0] timer_wrap_clear,
  input wire logic [3:0] channel_event,
  input wire logic [3:0] channel_event_irq_enable,
  input wire logic [3:0] channel_event_clear,
  input wire logic spi_rx_load,
  input wire logic spi_rx_read,
  input wire logic spi_rx_irq_enable,
  input wire logic spi_tx_load,
  input wire logic spi_tx_write,
  input wire logic spi_tx_irq_enable,
  input wire logic spi_role,
  input wire logic spi_busy,
  input wire logic spi_select_in,
  input wire logic spi_role_fault_detect_enable,
  input wire logic spi_fault_irq_enable,
  input wire logic spi_fault_clear,
  input wire logic uart_tx_load,
  input wire logic uart_tx_write,
  input wire logic uart_tx_irq_enable,
  input wire logic uart_shifter_empty,
  input wire logic uart_break_or_idle_tx,
  input wire logic uart_tx_done_irq_enable,
  input wire logic uart_rx_load,
  input wire logic uart_rx_read,
  input wire logic uart_rx_irq_enable,
  input wire logic uart_bit_tick,
  input wire logic uart_rx_bit,
  input wire logic uart_long_char,
  input wire logic uart_quiet_line_irq_enable,
  input wire logic uart_quiet_clear,
  input wire logic uart_noise_seen,
  input wire logic uart_stop_sample_low,
  input wire logic uart_parity_mismatch,
  input wire logic uart_rx_lost_irq_enable,
  input wire logic uart_noise_irq_enable,
  input wire logic uart_stop_bit_irq_enable,
  input wire logic uart_parity_irq_enable,
  input wire logic uart_err_clear,
  input wire logic [KEY_W-1:0] keypad_inputs,
  input wire logic keypad_clear,
  input wire logic conversion_end,
  input wire logic conversion_read,
  input wire logic converter_irq_enable,
  input wire logic [PIS_RATE_W-1:0] tick_rate_select,
  input wire logic tick_irq_enable,
  input wire logic tick_acknowledge,
  output logic [PIS_N_REQ-1:0] irq_request,
  output logic cpu_irq,
  output logic [3:0] flags_misc,
  output logic [3:0] channel_event_flag,
  output logic [1:0] timer_wrap_flag,
  output logic [3:0] spi_flags,
  output logic [3:0] uart_flags,
  output logic [3:0] uart_err_flags,
  output logic conversion_done_bit,
  output logic tick_rollover_flag
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ext_pend;
    logic lock_prev;
    logic lock_change_flag;
    logic [1:0] wrap;
    logic [3:0] chan;
    logic spi_rx_full_flag;
    logic spi_tx_empty_flag;
    logic spi_role_fault_flag;
    logic spi_rx_lost_flag;
    logic sel_low_prev;
    logic uart_tx_empty_flag;
    logic uart_tx_done_flag;
    logic uart_rx_full_flag;
    logic uart_quiet;
    logic [3:0] idle_cnt;
    logic uart_rx_lost;
    logic uart_noise_flag;
    logic uart_stop_bit_bad_flag;
    logic uart_parity_bad_flag;
    logic key_pend;
    logic conv_done;
    logic conv_bit;
    logic [PIS_TICK_W-1:0] tick_cnt;
    logic tick_flag;
    logic [PIS_N_REQ-1:0] req;
    logic cpu_irq;
  } pis_state_s;

  pis_state_s st_reg;
  pis_state_s st_next;
  logic [PIS_TICK_W-1:0] tick_period;
  logic [3:0] idle_target;

  // Tick period doubles per rate step
  assign tick_period = PIS_TICK_BASE << tick_rate_select;
  assign idle_target = uart_long_char ? PIS_IDLE_LONG_C : PIS_IDLE_SHORT_C;

  // ---------------------------------------------------------------
  // Next state: set wins over clear on every flag except transmit done, which uart_tx_write clears
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // (RL1) pin low latches
    st_next.ext_pend = !ext_request_pin || (st_reg.ext_pend && !ext_clear);
    // (RL2) lock toggle detect
    st_next.lock_prev = lock_status;
    st_next.lock_change_flag = (lock_status != st_reg.lock_prev) ||
      (st_reg.lock_change_flag && !lock_change_clear);
    for (int i = 0; i < 2; i++) begin
      // (RL3) wrap after modulo match
      st_next.wrap[i] = (timer_count_tick[i] &&
        timer_count[i*TMR_W +: TMR_W] == timer_modulo[i*TMR_W +: TMR_W]) ||
        (st_reg.wrap[i] && !timer_wrap_clear[i]);
    end
    // (RL4) channel events
    st_next.chan = channel_event | (st_reg.chan & ~channel_event_clear);
    // (RL5) receive full
    st_next.spi_rx_full_flag = spi_rx_load ||
      (st_reg.spi_rx_full_flag && !spi_rx_read);
    // (RL9) byte lands before read
    st_next.spi_rx_lost_flag = (spi_rx_load && st_reg.spi_rx_full_flag &&
      !spi_rx_read) || (st_reg.spi_rx_lost_flag && !spi_fault_clear);
    // (RL6) transmit empty
    st_next.spi_tx_empty_flag = spi_tx_load ||
      (st_reg.spi_tx_empty_flag && !spi_tx_write);
    // Stored inverted: reset value means select idle high, no false rise
    st_next.sel_low_prev = !spi_select_in;
    // (RL7) (RL8) role fault by role
    st_next.spi_role_fault_flag =
      (spi_role_fault_detect_enable && (spi_role == PIS_SPI_SLAVE) &&
       spi_busy && spi_select_in && st_reg.sel_low_prev) ||
      (spi_role_fault_detect_enable && (spi_role == PIS_SPI_MASTER) &&
       !spi_select_in) ||
      (st_reg.spi_role_fault_flag && !spi_fault_clear);
    // (RL10) UART transmit empty
    st_next.uart_tx_empty_flag = uart_tx_load ||
      (st_reg.uart_tx_empty_flag && !uart_tx_write);
    // (RL11) done only when all idle
    st_next.uart_tx_done_flag = (uart_shifter_empty &&
      st_next.uart_tx_empty_flag && !uart_break_or_idle_tx && !uart_tx_write);
    // (RL12) UART receive full
    st_next.uart_rx_full_flag = uart_rx_load ||
      (st_reg.uart_rx_full_flag && !uart_rx_read);
    // (RL13) count consecutive high bits
    if (uart_bit_tick) begin
      if (!uart_rx_bit) begin
        st_next.idle_cnt = PIS_IDLE_CNT_ZERO;
      end else if (st_reg.idle_cnt != idle_target) begin
        st_next.idle_cnt = st_reg.idle_cnt + PIS_IDLE_CNT_ONE;
      end
    end
    st_next.uart_quiet = (uart_bit_tick && uart_rx_bit &&
      st_reg.idle_cnt + PIS_IDLE_CNT_ONE == idle_target) ||
      (st_reg.uart_quiet && !uart_quiet_clear);
    // (RL14) overrun
    st_next.uart_rx_lost = (uart_rx_load && st_reg.uart_rx_full_flag &&
      !uart_rx_read) || (st_reg.uart_rx_lost && !uart_err_clear);
    // (RL15) noise
    st_next.uart_noise_flag = uart_noise_seen ||
      (st_reg.uart_noise_flag && !uart_err_clear);
    // (RL16) framing
    st_next.uart_stop_bit_bad_flag = uart_stop_sample_low ||
      (st_reg.uart_stop_bit_bad_flag && !uart_err_clear);
    // (RL17) parity
    st_next.uart_parity_bad_flag = uart_parity_mismatch ||
      (st_reg.uart_parity_bad_flag && !uart_err_clear);
    // (RL18) any keypad low
    st_next.key_pend = !(&keypad_inputs) ||
      (st_reg.key_pend && !keypad_clear);
    // (RL19) conversion end
    st_next.conv_done = conversion_end ||
      (st_reg.conv_done && !conversion_read);
    // (RL19) completion bit hidden when enabled
    st_next.conv_bit = st_next.conv_done && !converter_irq_enable;
    // (RL20) tick chain rollover
    if (st_reg.tick_cnt + PIS_TICK_ONE >= tick_period) begin
      st_next.tick_cnt = '0;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + PIS_TICK_ONE;
    end
    // (RL21) acknowledge by writing one
    st_next.tick_flag = (st_reg.tick_cnt + PIS_TICK_ONE >= tick_period) ||
      (st_reg.tick_flag && !tick_acknowledge);
    // (RL23) gate and combine requests
    st_next.req = '0;
    st_next.req[PIS_REQ_EXT] = st_reg.ext_pend;
    st_next.req[PIS_REQ_LOCK] = st_reg.lock_change_flag &&
      lock_change_irq_enable;
    st_next.req[PIS_REQ_TA_CH0] = st_reg.chan[0] && channel_event_irq_enable[0];
    st_next.req[PIS_REQ_TA_CH1] = st_reg.chan[1] && channel_event_irq_enable[1];
    st_next.req[PIS_REQ_TA_WRAP] = st_reg.wrap[0] && timer_wrap_irq_enable[0];
    st_next.req[PIS_REQ_TB_CH0] = st_reg.chan[2] && channel_event_irq_enable[2];
    st_next.req[PIS_REQ_TB_CH1] = st_reg.chan[3] && channel_event_irq_enable[3];
    st_next.req[PIS_REQ_TB_WRAP] = st_reg.wrap[1] && timer_wrap_irq_enable[1];
    st_next.req[PIS_REQ_SPI_RX] = (st_reg.spi_rx_full_flag && spi_rx_irq_enable)
      || ((st_reg.spi_role_fault_flag || st_reg.spi_rx_lost_flag) &&
      spi_fault_irq_enable);
    st_next.req[PIS_REQ_SPI_TX] = st_reg.spi_tx_empty_flag && spi_tx_irq_enable;
    st_next.req[PIS_REQ_UART_ERR] =
      (st_reg.uart_rx_lost && uart_rx_lost_irq_enable) ||
      (st_reg.uart_noise_flag && uart_noise_irq_enable) ||
      (st_reg.uart_stop_bit_bad_flag && uart_stop_bit_irq_enable) ||
      (st_reg.uart_parity_bad_flag && uart_parity_irq_enable);
    st_next.req[PIS_REQ_UART_RX] =
      (st_reg.uart_rx_full_flag && uart_rx_irq_enable) ||
      (st_reg.uart_quiet && uart_quiet_line_irq_enable);
    st_next.req[PIS_REQ_UART_TX] =
      (st_reg.uart_tx_empty_flag && uart_tx_irq_enable) ||
      (st_reg.uart_tx_done_flag && uart_tx_done_irq_enable);
    st_next.req[PIS_REQ_KEYPAD] = st_reg.key_pend;
    st_next.req[PIS_REQ_CONV] = st_reg.conv_done && converter_irq_enable;
    st_next.req[PIS_REQ_TICK] = st_reg.tick_flag && tick_irq_enable;
    // (RL22) global mask
    st_next.cpu_irq = (|st_next.req) && !global_mask;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign irq_request = st_reg.req;
  assign cpu_irq = st_reg.cpu_irq;
  assign flags_misc = {st_reg.key_pend, st_reg.uart_quiet,
    st_reg.lock_change_flag, st_reg.ext_pend};
  assign channel_event_flag = st_reg.chan;
  assign timer_wrap_flag = st_reg.wrap;
  assign spi_flags = {st_reg.spi_rx_lost_flag, st_reg.spi_role_fault_flag,
    st_reg.spi_tx_empty_flag, st_reg.spi_rx_full_flag};
  assign uart_flags = {st_reg.uart_rx_lost, st_reg.uart_rx_full_flag,
    st_reg.uart_tx_done_flag, st_reg.uart_tx_empty_flag};
  assign uart_err_flags = {st_reg.uart_parity_bad_flag,
    st_reg.uart_stop_bit_bad_flag, st_reg.uart_noise_flag, st_reg.uart_rx_lost};
  // Completion bit only when interrupts off
  assign conversion_done_bit = st_reg.conv_bit;
  assign tick_rollover_flag = st_reg.tick_flag;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_ext_latch: assert property (!ext_request_pin |=> st_reg.ext_pend) // RL1
    else $error("external request not latched");
  a_lock_toggle: assert property ($changed(lock_status) |=> // RL2
    st_reg.lock_change_flag)
    else $error("lock change not flagged");
  a_chan_set: assert property (channel_event[0] |=> st_reg.chan[0]) // RL4
    else $error("channel flag not set");
  a_spi_rx_full: assert property (spi_rx_load |=> // RL5
    st_reg.spi_rx_full_flag)
    else $error("spi receive full missing");
  a_master_fault: assert property (spi_role_fault_detect_enable && // RL8
    spi_role == PIS_SPI_MASTER && !spi_select_in |=>
    st_reg.spi_role_fault_flag)
    else $error("master fault missing");
  a_slave_fault: assert property (spi_role_fault_detect_enable && // RL7
    spi_role == PIS_SPI_SLAVE && spi_busy && $rose(spi_select_in) |=>
    st_reg.spi_role_fault_flag)
    else $error("slave fault missing");
  a_wrap_set: assert property (timer_count_tick[0] && // RL3
    timer_count[TMR_W-1:0] == timer_modulo[TMR_W-1:0] |=> st_reg.wrap[0])
    else $error("timer wrap flag missing");
  a_done_blocked: assert property (uart_break_or_idle_tx |=> // RL11
    !st_reg.uart_tx_done_flag)
    else $error("transmit done set during break");
  a_conv_bit_off: assert property (converter_irq_enable |=> // RL19
    !conversion_done_bit)
    else $error("completion bit shown while enabled");
  a_uart_err_req: assert property (st_reg.uart_parity_bad_flag && // RL17
    uart_parity_irq_enable |=> irq_request[PIS_REQ_UART_ERR])
    else $error("uart error request missing");
  a_key_latch: assert property (!(&keypad_inputs) |=> st_reg.key_pend) // RL18
    else $error("keypad not latched");
  a_tick_ack: assert property (st_reg.tick_flag && tick_acknowledge && // RL21
    st_reg.tick_cnt + PIS_TICK_ONE < tick_period |=> !st_reg.tick_flag)
    else $error("tick not acknowledged");
  a_mask_blocks: assert property (global_mask |=> !cpu_irq) // RL22
    else $error("mask did not block");
  a_stop_bad: assert property (uart_stop_sample_low |=> // RL16
    st_reg.uart_stop_bit_bad_flag)
    else $error("framing flag missing");

  c_tick_irq: cover property (tick_irq_enable ##[1:300] cpu_irq);
  c_uart_idle: cover property (st_reg.uart_quiet);
  c_spi_lost: cover property (st_reg.spi_rx_lost_flag);
  c_wrap: cover property (st_reg.wrap[1]);

endmodule : pis_sources

// file: src/pis_pkg.sv
// Package: constants and types for the peripheral interrupt source block
package pis_pkg;
  // Source indices on the request vector
  localparam int unsigned PIS_N_REQ = 16;
  localparam int unsigned PIS_REQ_EXT = 0;
  localparam int unsigned PIS_REQ_LOCK = 1;
  localparam int unsigned PIS_REQ_TA_CH0 = 2;
  localparam int unsigned PIS_REQ_TA_CH1 = 3;
  localparam int unsigned PIS_REQ_TA_WRAP = 4;
  localparam int unsigned PIS_REQ_TB_CH0 = 5;
  localparam int unsigned PIS_REQ_TB_CH1 = 6;
  localparam int unsigned PIS_REQ_TB_WRAP = 7;
  localparam int unsigned PIS_REQ_SPI_RX = 8;
  localparam int unsigned PIS_REQ_SPI_TX = 9;
  localparam int unsigned PIS_REQ_UART_ERR = 10;
  localparam int unsigned PIS_REQ_UART_RX = 11;
  localparam int unsigned PIS_REQ_UART_TX = 12;
  localparam int unsigned PIS_REQ_KEYPAD = 13;
  localparam int unsigned PIS_REQ_CONV = 14;
  localparam int unsigned PIS_REQ_TICK = 15;
  // Widths and documented values
  localparam int unsigned PIS_TMR_W = 16;
  localparam logic [15:0] PIS_TMR_WRAP_VAL = 16'h0000;
  localparam int unsigned PIS_KEY_W = 8;
  localparam int unsigned PIS_RATE_W = 3;
  localparam int unsigned PIS_TICK_W = 16;
  localparam int unsigned PIS_IDLE_SHORT = 10;
  localparam int unsigned PIS_IDLE_LONG = 11;
  localparam logic [3:0] PIS_IDLE_CNT_ZERO = 4'h0;
  localparam logic [3:0] PIS_IDLE_CNT_ONE = 4'h1;
  localparam logic [3:0] PIS_IDLE_SHORT_C = 4'hA;
  localparam logic [3:0] PIS_IDLE_LONG_C = 4'hB;
  localparam logic [15:0] PIS_TICK_ONE = 16'h0001;
  localparam logic [15:0] PIS_TICK_BASE = 16'h0008;
  // SPI role
  typedef enum logic {PIS_SPI_SLAVE, PIS_SPI_MASTER} pis_role_e;
endpackage : pis_pkg

// file: verification/pis_timer_model.sv
// Partner timer counters feeding the timer count ports
`timescale 1ns/10ps
module pis_timer_model
  import pis_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [31:0] modulo,
  output logic [1:0] timer_count_tick,
  output logic [31:0] timer_count,
  output logic [31:0] timer_modulo
);
  // ----------------------------------------
  // Counter model
  // ----------------------------------------
  // Both counters step every cycle while run is high, stall otherwise
  assign timer_count_tick = {run, run};
  assign timer_modulo = modulo;
  // wrap to zero after modulo match
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_count <= 32'h00000000;
    end else if (run) begin
      for (int i = 0; i < 2; i++) begin
        if (timer_count[i*16 +: 16] == modulo[i*16 +: 16]) begin
          timer_count[i*16 +: 16] <= PIS_TMR_WRAP_VAL;
        end else begin
          timer_count[i*16 +: 16] <= timer_count[i*16 +: 16] + 16'h0001;
        end
      end
    end
  end
endmodule : pis_timer_model

// file: verification/test_pis_sources.sv
// Self-checking bench for the interrupt source block
`timescale 1ns/10ps
module test_pis_sources
  import pis_pkg::*;
;
  logic ref_clk = 1'b0, rst_b = 1'b0, global_mask = 1'b0, run = 1'b0;
  logic ext_request_pin = 1'b1, lock_status = 1'b0, en = 1'b0;
  logic spi_role = 1'b0, spi_busy = 1'b0, spi_select_in = 1'b1;
  logic spi_role_fault_detect_enable = 1'b1, uart_shifter_empty = 1'b0;
  logic uart_break_or_idle_tx = 1'b0, uart_bit_tick = 1'b0;
  logic uart_rx_bit = 1'b1, uart_long_char = 1'b0;
  logic tick_irq_enable = 1'b0, tick_acknowledge = 1'b0;
  logic [7:0] keypad_inputs = 8'hFF;
  logic [2:0] tick_rate_select = 3'h0;
  logic [11:0] ev = 12'h000;
  logic [16:0] clr = 17'h00000;
  logic [31:0] modulo = 32'h00000000;
  logic [3:0] channel_event, channel_event_irq_enable, channel_event_clear;
  logic [1:0] timer_wrap_irq_enable, timer_wrap_clear, timer_count_tick;
  logic [31:0] timer_count, timer_modulo;
  logic spi_rx_load, spi_tx_load, uart_rx_load, uart_tx_load;
  logic uart_noise_seen, uart_stop_sample_low, uart_parity_mismatch;
  logic conversion_end, spi_rx_irq_enable, spi_tx_irq_enable;
  logic uart_rx_irq_enable, uart_noise_irq_enable, uart_stop_bit_irq_enable;
  logic uart_parity_irq_enable, converter_irq_enable, uart_tx_irq_enable;
  logic uart_tx_done_irq_enable, uart_rx_lost_irq_enable;
  logic uart_quiet_line_irq_enable, lock_change_irq_enable;
  logic spi_fault_irq_enable, ext_clear, lock_change_clear, spi_fault_clear;
  logic uart_quiet_clear, uart_err_clear, keypad_clear, spi_rx_read;
  logic spi_tx_write, uart_rx_read, uart_tx_write, conversion_read;
  logic [15:0] irq_request;
  logic cpu_irq, conversion_done_bit, tick_rollover_flag;
  logic [3:0] flags_misc, channel_event_flag, spi_flags, uart_flags;
  logic [3:0] uart_err_flags;
  logic [1:0] timer_wrap_flag;
  logic [11:0] v = 12'h000;
  logic [14:0] flg;
  int mismatches = 0, checked = 0, seed = 4, n, wa, wb;
  // ----------------------------------------
  // Stimulus groups and instances
  // ----------------------------------------
  // Event pulses, enables and clear pulses as grouped vectors
  assign {uart_tx_load, conversion_end, uart_parity_mismatch,
    uart_stop_sample_low, uart_noise_seen, uart_rx_load, spi_tx_load,
    spi_rx_load, channel_event} = ev;
  assign {channel_event_irq_enable, spi_rx_irq_enable, spi_tx_irq_enable,
    uart_rx_irq_enable, uart_noise_irq_enable, uart_stop_bit_irq_enable,
    uart_parity_irq_enable, converter_irq_enable, uart_tx_irq_enable,
    uart_tx_done_irq_enable, uart_rx_lost_irq_enable,
    uart_quiet_line_irq_enable, lock_change_irq_enable,
    timer_wrap_irq_enable, spi_fault_irq_enable} = {19{en}};
  assign {ext_clear, lock_change_clear, timer_wrap_clear, channel_event_clear,
    spi_fault_clear, uart_quiet_clear, uart_err_clear, keypad_clear,
    spi_rx_read, spi_tx_write, uart_rx_read, uart_tx_write,
    conversion_read} = clr;
  // Flags of the single-event table in event order
  assign flg = {uart_flags, uart_err_flags[3:1], spi_flags,
    channel_event_flag};
  pis_sources dut_u (.*);
  pis_timer_model tmr_u (.ref_clk, .rst_b, .run, .modulo, .timer_count_tick,
    .timer_count, .timer_modulo);
  // Free-running clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic rst;
    @(negedge ref_clk);
    rst_b = 1'b0;
    cyc(3);
    rst_b = 1'b1;
  endtask : rst
  task automatic fire(input logic [11:0] v);
    ev = v;
    cyc(1);
    ev = 12'h000;
    cyc(2);
  endtask : fire
  task automatic clear_all;
    clr = 17'h1FFFF;
    cyc(1);
    clr = 17'h00000;
    cyc(2);
  endtask : clear_all
  // Request vector expected for one event of the table
  function automatic logic [15:0] req_of(input int i, input logic e);
    int rq[12] = '{2, 3, 5, 6, 8, 9, 11, 10, 10, 10, 14, 12};
    return e ? (16'h0001 << rq[i]) : 16'h0000;
  endfunction : req_of
  // Flag vector expected for one event of the table
  function automatic logic [14:0] flg_of(input logic [11:0] e);
    return {1'b0, e[6], 1'b0, e[11], e[9:7], 2'h0, e[5:4], e[3:0]};
  endfunction : flg_of
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst();
    ext_request_pin = 1'b0;
    cyc(1);
    ext_request_pin = 1'b1;
    cyc(2);
    chk({flags_misc[0], irq_request, cpu_irq}, 18'h20003);
    global_mask = 1'b1;
    cyc(2);
    chk(cpu_irq, 1'b0);
    global_mask = 1'b0;
    keypad_inputs = ~(8'h01 << ($random(seed) & 7));
    cyc(1);
    keypad_inputs = 8'hFF;
    cyc(2);
    chk({flags_misc[3], irq_request[13]}, 2'h3);
    clear_all();
    chk({flags_misc, irq_request}, 20'h00000);
    for (int i = 0; i < 12; i++) begin
      rst();
      en = 1'($random(seed));
      v = 12'h001 << i;
      fire(v);
      chk(flg, flg_of(v));
      chk({irq_request, cpu_irq}, {req_of(i, en), en});
      chk(conversion_done_bit, (i == 10) && !en);
      clear_all();
      chk(irq_request, 16'h0000);
    end
    rst();
    en = 1'b1;
    fire(12'h050);
    fire(12'h050);
    chk({spi_flags[3], uart_err_flags[0], irq_request[10]}, 3'h7);
    uart_shifter_empty = 1'b1;
    fire(12'h800);
    chk({uart_flags[1:0], irq_request[12]}, 3'h7);
    uart_break_or_idle_tx = 1'b1;
    cyc(1);
    chk(uart_flags[1], 1'b0);
    uart_break_or_idle_tx = 1'b0;
    uart_shifter_empty = 1'b0;
    for (int r = 0; r < 2; r++) begin
      spi_role = r[0];
      spi_busy = 1'b1;
      spi_select_in = r[0];
      rst();
      cyc(1);
      spi_select_in = !r[0];
      cyc(3);
      chk({spi_flags[2], irq_request[8]}, 2'h3);
      spi_select_in = 1'b1;
      spi_busy = 1'b0;
    end
    for (int l = 0; l < 2; l++) begin
      uart_long_char = l[0];
      rst();
      for (int b = 0; b < 10 + l; b++) begin
        chk(flags_misc[2], 1'b0);
        uart_bit_tick = 1'b1;
        cyc(1);
        uart_bit_tick = 1'b0;
        cyc(2);
      end
      chk({flags_misc[2], irq_request[11]}, 2'h3);
    end
    for (int t = 0; t < 2; t++) begin
      clear_all();
      lock_status = !lock_status;
      cyc(3);
      chk({flags_misc[1], irq_request[1]}, 2'h3);
    end
    modulo = {12'h000, 4'($random(seed)), 12'h000, 4'($random(seed))};
    rst();
    run = 1'b1;
    wa = 0;
    wb = 0;
    for (int k = 1; k < 20; k++) begin
      cyc(1);
      if (timer_wrap_flag[0] === 1'b1 && wa == 0) wa = k;
      if (timer_wrap_flag[1] === 1'b1 && wb == 0) wb = k;
    end
    chk(wa, modulo[15:0] + 32'h1);
    chk(wb, modulo[31:16] + 32'h1);
    chk({irq_request[7], irq_request[4]}, 2'h3);
    run = 1'b0;
    tick_rate_select = 3'($random(seed));
    tick_irq_enable = 1'b1;
    rst();
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (tick_rollover_flag !== 1'b1 && n < 2000) begin
        cyc(1);
        n++;
      end
      chk(n, (8 << tick_rate_select) - 3 * k);
      cyc(1);
      chk(irq_request[15], 1'b1);
      tick_acknowledge = 1'b1;
      cyc(1);
      tick_acknowledge = 1'b0;
      cyc(1);
      chk(tick_rollover_flag, 1'b0);
    end
    summarize();
  end
  // Watchdog cuts a hung run short
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule : test_pis_sources
